// ---- verilog/core_slice_pkg.sv ----
// constants, opcodes and register map of the instruction execution slice
package core_slice_pkg;
  localparam int unsigned RAM_DEPTH = 208;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned PC_W = 15;
  // byte offsets of the register window
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_WORK = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_PC = 8'h0c;
  localparam logic [7:0] OFF_MEM_ADDR = 8'h10;
  localparam logic [7:0] OFF_MEM_DATA = 8'h14;
  localparam logic [7:0] OFF_STACK = 8'h18;
  // instruction word fields
  localparam int unsigned OP_LSB = 0;
  localparam int unsigned OPND_LSB = 8;
  localparam int unsigned TARGET_LSB = 16;
  // status bit positions
  localparam int unsigned ST_EXPIRY = 0;
  localparam int unsigned ST_PDOWN = 1;
  localparam int unsigned ST_EXCESS = 2;
  localparam int unsigned ST_ZERO = 3;
  localparam int unsigned ST_HALF = 4;
  localparam int unsigned ST_CARRY = 5;
  localparam int unsigned ST_GIE = 6;
  localparam int unsigned ST_HALTED = 7;
  localparam int unsigned ST_BUSY = 8;
  localparam int unsigned ST_WAKE = 8;
  localparam int unsigned FLAG_W = 7;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 7'h00;
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  // machine cycles of a return
  localparam int unsigned RETURN_CYCLES = 2;
  typedef enum logic [3:0] {
    halt_op, add_one_to_mem_op, add_one_to_work_op, direct_branch_op,
    copy_op, copy_imm_op, copy_to_mem_op, idle_op,
    or_op, or_imm_op, or_to_memory_op, stack_pop_branch_op,
    pop_with_const_op, interrupt_exit_op, rotate_left_op,
    rotate_left_to_work_op
  } op_t;
  typedef enum {st_idle, st_exec, st_second} exec_state_t;
endpackage

// ---- verilog/core_slice.sv ----
// execution unit for halt, increment, branch, copy, or, return and rotate
`timescale 1ns/1ns
// Overview of operation
// - halt stops execution, keeps state, pc+1, power-down set, expiry cleared
// - plain return pops pc from stack in two cycles, flags unchanged
// - return-with-constant pops pc and loads immediate into work register
// - interrupt exit pops pc and sets global interrupt enable
// - load-immediate copy puts constant into work register, no flags
// - store copy writes work register to addressed memory, no flags
// - in-place rotate left: bits shift up, bit 7 into bit 0
// - rotate to work register: same rotation, memory and flags kept
module core_slice
  import core_slice_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  logic [7:0] mem [RAM_DEPTH];
  logic [PC_W-1:0] stack [STACK_DEPTH];
  logic [2:0] sp_reg;
  logic [31:0] instr_reg;
  logic [7:0] work_reg;
  logic [FLAG_W-1:0] flags_reg;
  logic halted_reg;
  logic [PC_W-1:0] pc_reg;
  logic [7:0] mem_addr_reg;
  logic [31:0] prdata_reg;
  exec_state_t state_reg;

  logic [7:0] off;
  logic addr_ok, wr_en, setup;
  logic [3:0] op_code;
  op_t op;
  logic [7:0] opnd, rd, rot, inc, ored, result;
  logic exec, pop_now, mem_we, work_we, zero_we, to_mem, issue;
  logic [PC_W-1:0] top;

  assign off = paddr[7:0];
  assign addr_ok = (paddr[31:8] == 24'h000000) && (off[1:0] == 2'b00)
                   && (off <= OFF_STACK);
  assign pready = clk_en;
  assign pslverr = psel && penable && !addr_ok;
  assign setup = clk_en && psel && !penable;
  assign wr_en = clk_en && psel && penable && pwrite && addr_ok;
  assign prdata = prdata_reg;

  assign op_code = instr_reg[OP_LSB +: 4];
  assign op = op_t'(op_code);
  assign opnd = instr_reg[OPND_LSB +: 8];
  // out-of-range addresses read as zero and ignore writes
  assign rd = (opnd < RAM_DEPTH) ? mem[opnd] : 8'h00;
  assign rot = {rd[6:0], rd[7]};
  assign inc = rd + 8'h01;
  assign ored = work_reg | ((op == or_imm_op) ? opnd : rd);
  assign top = stack[sp_reg - 3'd1];
  assign exec = clk_en && (state_reg == st_exec);
  assign pop_now = clk_en && (state_reg == st_second);
  // instruction writes are dropped while busy or halted
  assign issue = wr_en && (off == OFF_INSTR) && (state_reg == st_idle)
                 && !halted_reg;

  always_comb begin
    to_mem = 1'b0;
    work_we = 1'b0;
    zero_we = 1'b0;
    result = 8'h00;
    unique case (op)
      add_one_to_mem_op: begin
        to_mem = 1'b1;
        zero_we = 1'b1;
        result = inc;
      end
      add_one_to_work_op: begin
        work_we = 1'b1;
        zero_we = 1'b1;
        result = inc;
      end
      copy_op: begin
        work_we = 1'b1;
        result = rd;
      end
      copy_imm_op: begin
        work_we = 1'b1;
        result = opnd;
      end
      copy_to_mem_op: begin
        to_mem = 1'b1;
        result = work_reg;
      end
      or_op, or_imm_op: begin
        work_we = 1'b1;
        zero_we = 1'b1;
        result = ored;
      end
      or_to_memory_op: begin
        to_mem = 1'b1;
        zero_we = 1'b1;
        result = ored;
      end
      rotate_left_op: begin
        to_mem = 1'b1;
        result = rot;
      end
      rotate_left_to_work_op: begin
        work_we = 1'b1;
        result = rot;
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end
  assign mem_we = exec && to_mem && (opnd < RAM_DEPTH);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= st_idle;
    end else if (clk_en) begin
      unique case (state_reg)
        st_idle: if (issue) state_reg <= st_exec;
        st_exec: begin
          if (op == stack_pop_branch_op || op == pop_with_const_op ||
              op == interrupt_exit_op) begin
            state_reg <= st_second;
          end else begin
            state_reg <= st_idle;
          end
        end
        st_second: state_reg <= st_idle;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_reg <= 32'h00000000;
    end else if (issue) begin
      instr_reg <= pwdata;
    end
  end

  // array has no reset; software writes win only when no store executes
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[opnd] <= result;
    end else if (wr_en && off == OFF_MEM_DATA
                 && mem_addr_reg < RAM_DEPTH) begin
      mem[mem_addr_reg] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work_reg <= WORK_RST;
    end else if (exec && work_we) begin
      work_reg <= result;
    end else if (pop_now && op == pop_with_const_op) begin
      work_reg <= opnd;
    end else if (wr_en && off == OFF_WORK) begin
      work_reg <= pwdata[7:0];
    end
  end

  // hardware updates of a flag win over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= FLAGS_RST;
    end else if (exec && op == halt_op) begin
      flags_reg[ST_PDOWN] <= 1'b1;
      flags_reg[ST_EXPIRY] <= 1'b0;
    end else if (exec && zero_we) begin
      flags_reg[ST_ZERO] <= (result == 8'h00);
    end else if (pop_now && op == interrupt_exit_op) begin
      flags_reg[ST_GIE] <= 1'b1;
    end else if (wr_en && off == OFF_STATUS) begin
      flags_reg <= pwdata[FLAG_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted_reg <= 1'b0;
    end else if (exec && op == halt_op) begin
      halted_reg <= 1'b1;
    end else if (wr_en && off == OFF_STATUS && pwdata[ST_WAKE]) begin
      halted_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg <= PC_RST;
    end else if (exec && op == direct_branch_op) begin
      pc_reg <= instr_reg[TARGET_LSB +: PC_W];
    end else if (exec && state_reg == st_exec && !(op == stack_pop_branch_op
                 || op == pop_with_const_op || op == interrupt_exit_op)) begin
      pc_reg <= pc_reg + 15'h0001;
    end else if (pop_now) begin
      pc_reg <= top;
    end else if (wr_en && off == OFF_PC) begin
      pc_reg <= pwdata[PC_W-1:0];
    end
  end

  // circular return stack; overflow overwrites the oldest entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_reg <= 3'd0;
    end else if (pop_now) begin
      sp_reg <= sp_reg - 3'd1;
    end else if (wr_en && off == OFF_STACK) begin
      sp_reg <= sp_reg + 3'd1;
    end
  end

  always_ff @(posedge pclk) begin
    if (!pop_now && wr_en && off == OFF_STACK) begin
      stack[sp_reg] <= pwdata[PC_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr_reg <= 8'h00;
    end else if (wr_en && off == OFF_MEM_ADDR) begin
      mem_addr_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (setup) begin
      unique case (off)
        OFF_INSTR: prdata_reg <= instr_reg;
        OFF_WORK: prdata_reg <= {24'h000000, work_reg};
        OFF_STATUS: prdata_reg <= {23'h000000, state_reg != st_idle,
                                   halted_reg, flags_reg};
        OFF_PC: prdata_reg <= {17'h00000, pc_reg};
        OFF_MEM_ADDR: prdata_reg <= {24'h000000, mem_addr_reg};
        OFF_MEM_DATA: prdata_reg <= (mem_addr_reg < RAM_DEPTH) ?
                                    {24'h000000, mem[mem_addr_reg]} : 32'h0;
        OFF_STACK: prdata_reg <= {29'h00000000, sp_reg};
        default: prdata_reg <= 32'h00000000;
      endcase
    end
  end

  logic [5:0] kept;
  assign kept = {flags_reg[ST_GIE:ST_HALF], flags_reg[ST_EXCESS:ST_EXPIRY]};
  sequence s_do(op_t o);
    exec && op == o;
  endsequence
  sequence s_pop(op_t o);
    pop_now && op == o;
  endsequence

  a_halt_power_down: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_do(halt_op) |=> halted_reg && flags_reg[ST_PDOWN]
      && !flags_reg[ST_EXPIRY] && pc_reg == $past(pc_reg) + 15'h0001)
    else $error("halt did not enter power down");
  // the pop edge is the one after entering the second cycle
  a_return_two_cycles: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_do(stack_pop_branch_op) |=> state_reg == st_second && $stable(flags_reg)
      ##1 !$past(clk_en) || (pc_reg == $past(top) && $stable(flags_reg)))
    else $error("return not completed in two cycles");
  a_return_const_work: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_pop(pop_with_const_op) |=> work_reg == $past(opnd)
      && pc_reg == $past(top) && $stable(flags_reg))
    else $error("return with constant wrong");
  a_irq_exit_enable: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_pop(interrupt_exit_op) |=> flags_reg[ST_GIE] && pc_reg == $past(top)
      && $stable(flags_reg[ST_CARRY:ST_EXPIRY]))
    else $error("interrupt exit wrong");
  a_copy_imm_work: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_do(copy_imm_op) |=> work_reg == $past(opnd) && $stable(flags_reg))
    else $error("immediate copy wrong");
  a_store_work_mem: assert property (@(posedge pclk)
    disable iff (!presetn)
    (s_do(copy_to_mem_op) ##0 (opnd < RAM_DEPTH)) |=>
      mem[$past(opnd)] == $past(work_reg) && $stable(flags_reg))
    else $error("store copy wrong");
  a_rotate_in_place: assert property (@(posedge pclk)
    disable iff (!presetn)
    (s_do(rotate_left_op) ##0 (opnd < RAM_DEPTH)) |=>
      mem[$past(opnd)] == {$past(rd[6:0]), $past(rd[7])} && $stable(flags_reg))
    else $error("rotate in place wrong");
  a_rotate_to_work: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_do(rotate_left_to_work_op) |=> work_reg == {$past(rd[6:0]),
      $past(rd[7])} && $stable(flags_reg))
    else $error("rotate to work wrong");
  a_add_one_zero: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_do(add_one_to_work_op) |=> work_reg == $past(inc)
      && flags_reg[ST_ZERO] == (work_reg == 8'h00) && $stable(kept))
    else $error("add one wrong");
  a_or_zero_only: assert property (@(posedge pclk)
    disable iff (!presetn)
    (s_do(or_op) or s_do(or_imm_op)) |=> work_reg == $past(ored)
      && flags_reg[ST_ZERO] == (work_reg == 8'h00) && $stable(kept))
    else $error("or result wrong");
endmodule

// ---- sim/tb_core_slice.sv ----
// self-checking bench for the instruction execution slice
`timescale 1ns/1ns
module tb_core_slice
  import core_slice_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd_v;
  logic rd_err;
  int error_cnt = 0;
  int check_count = 0;

  core_slice dut_u (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  initial begin
    forever #5 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
    rd_v = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] e,
                            input string m);
    xfer(1'b0, a, 32'h0);
    chk(rd_v, e, m);
  endtask

  // issue an instruction word, then poll busy so the next one is legal
  task automatic issue_word(input logic [31:0] w);
    int n;
    xfer(1'b1, OFF_INSTR, w);
    n = 0;
    do begin
      xfer(1'b0, OFF_STATUS, 32'h0);
      n++;
    end while (rd_v[ST_BUSY] !== 1'b0 && n < 20);
    if (rd_v[ST_BUSY] !== 1'b0) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  task automatic run(input op_t op, input logic [7:0] x);
    issue_word({16'h0, x, 4'h0, op});
  endtask

  task automatic poke(input logic [7:0] a, input logic [7:0] v);
    xfer(1'b1, OFF_MEM_ADDR, {24'h0, a});
    xfer(1'b1, OFF_MEM_DATA, {24'h0, v});
  endtask

  task automatic peek(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b1, OFF_MEM_ADDR, {24'h0, a});
    expect_reg(OFF_MEM_DATA, {24'h0, e}, "memory byte");
  endtask

  task automatic t_halt();
    xfer(1'b1, OFF_STATUS, 32'h01);
    xfer(1'b1, OFF_PC, 32'h5);
    xfer(1'b1, OFF_WORK, 32'h3c);
    poke(8'h40, 8'h77);
    run(halt_op, 8'h00);
    expect_reg(OFF_STATUS, 32'h082, "halt status");
    expect_reg(OFF_PC, 32'h6, "halt pc");
    expect_reg(OFF_WORK, 32'h3c, "halt work");
    peek(8'h40, 8'h77);
    // issue while halted must not execute
    xfer(1'b1, OFF_INSTR, {28'h0, idle_op});
    expect_reg(OFF_PC, 32'h6, "pc while halted");
    xfer(1'b1, OFF_STATUS, 32'h100);
    // after wake the core executes again
    issue_word({1'b0, 15'h1a2b, 8'h00, 4'h0, direct_branch_op});
    expect_reg(OFF_PC, 32'h1a2b, "branch pc");
    run(idle_op, 8'h00);
    expect_reg(OFF_PC, 32'h1a2c, "idle pc");
    expect_reg(OFF_STATUS, 32'h00, "idle flags");
    $display("test halt done");
  endtask

  task automatic t_return();
    xfer(1'b1, OFF_STACK, 32'h1234);
    xfer(1'b1, OFF_STACK, 32'h0abc);
    xfer(1'b1, OFF_STACK, 32'h0077);
    xfer(1'b1, OFF_STATUS, 32'h3f);
    run(stack_pop_branch_op, 8'h00);
    expect_reg(OFF_PC, 32'h0077, "return pc");
    expect_reg(OFF_STATUS, 32'h3f, "return flags");
    run(pop_with_const_op, 8'h5a);
    expect_reg(OFF_PC, 32'h0abc, "const return pc");
    expect_reg(OFF_WORK, 32'h5a, "const return work");
    expect_reg(OFF_STATUS, 32'h3f, "const return flags");
    run(interrupt_exit_op, 8'h00);
    expect_reg(OFF_PC, 32'h1234, "irq exit pc");
    expect_reg(OFF_STATUS, 32'h7f, "irq exit flags");
    expect_reg(OFF_STACK, 32'h0, "stack depth");
    $display("test return done");
  endtask

  task automatic t_copy();
    xfer(1'b1, OFF_STATUS, 32'h08);
    // a pending instruction must wait while the clock enable is low
    xfer(1'b1, OFF_WORK, 32'h11);
    xfer(1'b1, OFF_INSTR, {16'h0, 8'h66, 4'h0, copy_imm_op});
    clk_en <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, pready}, 32'h0, "ready while frozen");
    chk({24'h0, dut_u.work_reg}, 32'h11, "work while frozen");
    clk_en <= 1'b1;
    expect_reg(OFF_WORK, 32'h66, "work after freeze");
    poke(8'h50, 8'h3e);
    run(copy_op, 8'h50);
    expect_reg(OFF_WORK, 32'h3e, "copy from memory");
    expect_reg(OFF_STATUS, 32'h08, "copy from memory flags");
    run(copy_imm_op, 8'ha5);
    expect_reg(OFF_WORK, 32'ha5, "imm copy");
    expect_reg(OFF_STATUS, 32'h08, "imm copy flags");
    // highest data location
    run(copy_to_mem_op, 8'hcf);
    peek(8'hcf, 8'ha5);
    expect_reg(OFF_STATUS, 32'h08, "store flags");
    $display("test copy done");
  endtask

  task automatic t_rot();
    xfer(1'b1, OFF_STATUS, 32'h24);
    poke(8'h20, 8'h96);
    run(rotate_left_to_work_op, 8'h20);
    expect_reg(OFF_WORK, 32'h2d, "rotate to work");
    peek(8'h20, 8'h96);
    expect_reg(OFF_STATUS, 32'h24, "rotate work flags");
    run(rotate_left_op, 8'h20);
    peek(8'h20, 8'h2d);
    expect_reg(OFF_STATUS, 32'h24, "rotate flags");
    $display("test rotate done");
  endtask

  task automatic t_inc_or();
    xfer(1'b1, OFF_STATUS, 32'h37);
    poke(8'h30, 8'hff);
    run(add_one_to_work_op, 8'h30);
    expect_reg(OFF_WORK, 32'h00, "inc wrap");
    expect_reg(OFF_STATUS, 32'h3f, "inc zero set");
    peek(8'h30, 8'hff);
    poke(8'h31, 8'h41);
    run(add_one_to_mem_op, 8'h31);
    peek(8'h31, 8'h42);
    expect_reg(OFF_STATUS, 32'h37, "inc zero clear");
    xfer(1'b1, OFF_WORK, 32'h0f);
    run(or_imm_op, 8'hf0);
    expect_reg(OFF_WORK, 32'hff, "or imm");
    expect_reg(OFF_STATUS, 32'h37, "or imm flags");
    xfer(1'b1, OFF_WORK, 32'h00);
    poke(8'h32, 8'h00);
    run(or_op, 8'h32);
    expect_reg(OFF_STATUS, 32'h3f, "or zero");
    xfer(1'b1, OFF_WORK, 32'h81);
    run(or_to_memory_op, 8'h31);
    peek(8'h31, 8'hc3);
    expect_reg(OFF_WORK, 32'h81, "or to mem work");
    expect_reg(OFF_STATUS, 32'h37, "or to mem flags");
    // unmapped offset answers with an error and zero data
    xfer(1'b0, 8'h20, 32'h0);
    chk({31'h0, rd_err}, 32'h1, "unmapped error");
    chk(rd_v, 32'h0, "unmapped data");
    $display("test inc and or done");
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_halt();
    t_return();
    t_copy();
    t_rot();
    t_inc_or();
    report_and_stop();
  end
endmodule
